// file: design/oms_pkg.sv
/*
  shared constants, types and carriers of the operating mode sequencer.
  assumes a single 10 MHz clock; every count below derives from it.
*/
package oms_pkg;

  ////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_FREQ_MHZ = 10; // core clock rate
  localparam int unsigned PWRON_MIN_US = 100; // least low time of power-on line
  localparam int unsigned PWRON_MIN_CYC = PWRON_MIN_US * CLK_FREQ_MHZ;
  localparam int unsigned SWITCH_US = 20; // switch-on / wake / switch-off routine
  localparam int unsigned SWITCH_CYC = SWITCH_US * CLK_FREQ_MHZ;
  localparam int unsigned DWELL_US = 50; // least stay in active before sleeping
  localparam int unsigned DWELL_CYC = DWELL_US * CLK_FREQ_MHZ;
  // edrx cycle, in ms, from which deep sleep is allowed (327.68 s)
  localparam logic [31:0] EDRX_DS_MIN_MS = 32'h0005_0000;

  ////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_IDLE_BASE = 8'h04;
  localparam logic [7:0] OFS_EDRX_CYCLE = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h18;
  localparam logic [7:0] OFS_CMD = 8'h1c;

  // reset values
  localparam logic [5:0] CTRL_RST = 6'h00; // low power off by default
  localparam logic [31:0] IDLE_BASE_RST = 32'h0000_03e8;
  localparam logic [31:0] EDRX_CYCLE_RST = 32'h0000_0000;
  localparam logic [3:0] IRQ_RST = 4'h0;

  // control fields
  localparam int unsigned CTRL_LP_EN = 0; // low_power_config_cmd
  localparam int unsigned CTRL_PSM_EN = 1; // psm_setting_cmd
  localparam int unsigned CTRL_EDRX_EN = 2; // edrx_setting_cmd
  localparam int unsigned CTRL_POS_EN = 3; // positioning_enable_cmd
  localparam int unsigned CTRL_LPM_LSB = 4; // 2-bit low power profile
  localparam int unsigned CMD_POWEROFF = 0; // graceful_poweroff_cmd

  // interrupt bits
  localparam int unsigned IRQ_MODE = 0; // any mode change
  localparam int unsigned IRQ_WAKE = 1; // left idle for active or deep sleep for switch-on
  localparam int unsigned IRQ_OFF = 2; // graceful switch-off finished
  localparam int unsigned IRQ_SUPPLY = 3; // supply lost while powered

  ////////////////////////////////////////////////////////////////////////
  // modes as reported on the status output
  typedef enum logic [2:0] {
    ST_NOT_POWERED = 3'b000,
    ST_POWER_OFF = 3'b001,
    ST_DEEP_SLEEP = 3'b010,
    ST_IDLE = 3'b011,
    ST_ACTIVE = 3'b100,
    ST_CONNECTED = 3'b101,
    ST_SWITCH_ON = 3'b110,
    ST_SWITCH_OFF = 3'b111
  } oms_state_e;

  // product variant strap
  typedef enum logic [1:0] {
    VAR_EARLY_SUPPLY = 2'b00, // supply-triggered, no edrx deep sleep
    VAR_SUPPLY = 2'b01, // supply-triggered
    VAR_LINE = 2'b10 // power-on line triggered
  } oms_variant_e;

  // network and concurrent activity indications
  typedef struct packed {
    logic radio_active; // rf rx/tx in progress
    logic psm_allowed; // psm negotiated and timer running
    logic psm_timer_expiry; // periodic update timer expired, pulse
    logic ptw_start; // paging_time_window opens, pulse
    logic ptw_active; // inside paging_time_window
    logic positioning_busy; // positioning job running
  } oms_net_s;

endpackage : oms_pkg

// file: design/oms_pwron_filter.sv
/*
  qualifies the active-low power-on line: one pulse once it has been held
  low for the least valid time. assumes the line is synchronous.
*/
`timescale 1ns/1ps
module oms_pwron_filter
  import oms_pkg::*;
#(
  parameter int unsigned MIN_CYC = PWRON_MIN_CYC
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic power_on_request_n,
  output logic pulse
);

  logic [15:0] low_cnt; // cycles the line has been low, saturating
  logic fired; // one pulse per low hold

  // count low time, fire once when the least time is reached
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      low_cnt <= 16'h0000;
      fired <= 1'b0;
      pulse <= 1'b0;
    end
    else if (power_on_request_n)
    begin
      // line back high: rearm
      low_cnt <= 16'h0000;
      fired <= 1'b0;
      pulse <= 1'b0;
    end
    else
    begin
      if (low_cnt != 16'hffff)
        low_cnt <= low_cnt + 16'h0001;
      pulse <= !fired && (low_cnt == 16'(MIN_CYC - 1));
      if (low_cnt == 16'(MIN_CYC - 1))
        fired <= 1'b1;
    end
  end

endmodule : oms_pwron_filter

// file: design/oms_interval_timer.sv
/*
  down counter for the low power idle interval. assumes load and stop are
  never raised in the same cycle; load wins if they are.
*/
`timescale 1ns/1ps
module oms_interval_timer
#(
  parameter int unsigned WIDTH = 32
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic load,
  input wire logic stop,
  input wire logic [WIDTH-1:0] value,
  output logic expired
);

  logic [WIDTH-1:0] remain; // cycles left
  logic running; // counting

  // load, count down, pulse once at zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      remain <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end
    else if (load)
    begin
      // a zero load still gives one cycle of sleep
      remain <= (value == '0) ? WIDTH'(1) : value;
      running <= 1'b1;
      expired <= 1'b0;
    end
    else if (stop)
    begin
      running <= 1'b0;
      expired <= 1'b0;
    end
    else
    begin
      expired <= running && (remain == WIDTH'(1));
      if (running)
        remain <= remain - WIDTH'(1);
      if (running && (remain == WIDTH'(1)))
        running <= 1'b0;
    end
  end

endmodule : oms_interval_timer

// file: design/oms_sequencer.sv
/*
  operating mode sequencer top: ahb-lite register slave, mode state machine,
  clock/domain controls and interrupt. assumes one 10 MHz clock, a static
  variant strap and network indications synchronous to hclk.
*/
// Local design decisions: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module oms_sequencer
  import oms_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // supply, strap, power-on line and network
  input wire logic supply_valid,
  input wire logic [1:0] variant_sel,
  input wire logic power_on_request_n,
  input wire oms_net_s net,
  // mode and domain controls
  output oms_state_e mode_status,
  output logic rtc_run,
  output logic core_run,
  output logic core_clk_fast,
  output logic if_ready,
  output logic radio_path_en,
  output logic vint_on,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  oms_state_e state; // current mode
  oms_state_e next_state; // mode after this edge
  logic [5:0] ctrl; // low power configuration
  logic [31:0] idle_base; // base idle interval, cycles
  logic [31:0] edrx_cycle; // configured edrx cycle, ms
  logic [3:0] irq_status; // sticky events
  logic [3:0] irq_enable; // event mask
  logic [3:0] irq_event; // events of this cycle
  logic [3:0] irq_clear; // clear strobe from the bus
  logic poweroff_pend; // graceful switch-off requested
  logic poweroff_set; // command write this cycle
  logic deep_edrx; // current deep sleep is edrx, else psm
  logic [15:0] seq_cnt; // routine and dwell counter
  logic wr_pend; // write data phase pending
  logic [7:0] wr_addr; // address of that write
  logic addr_ok; // valid address phase
  logic wr_fire; // write lands this cycle
  logic cmd_ok; // host commands accepted
  logic pwr_pulse; // qualified power-on request
  logic idle_expired; // idle interval over
  logic idle_load; // start idle interval
  logic [31:0] idle_len; // computed interval
  logic lp_en; // low power enabled
  logic pos_busy; // positioning enabled and running
  logic psm_ok; // psm deep sleep possible
  logic edrx_ok; // edrx deep sleep possible
  logic line_variant; // switch-on by power-on line
  logic edrx_variant; // edrx sleep supported
  logic seq_done; // routine finished
  logic dwell_done; // active dwell over

  // true in modes where host commands are taken
  function automatic logic cmd_mode(input oms_state_e s);
    cmd_mode = (s == ST_IDLE) || (s == ST_ACTIVE) || (s == ST_CONNECTED);
  endfunction : cmd_mode

  // true where the interface supply is up
  function automatic logic vint_mode(input oms_state_e s);
    vint_mode = (s != ST_NOT_POWERED) && (s != ST_POWER_OFF) && (s != ST_DEEP_SLEEP);
  endfunction : vint_mode

  ////////////////////////////////////////////////////////////////////////
  // leaves
  oms_pwron_filter #(
    .MIN_CYC(PWRON_MIN_CYC)
  ) u_filter (
    .hclk(hclk),
    .hresetn(hresetn),
    .power_on_request_n(power_on_request_n),
    .pulse(pwr_pulse)
  );

  oms_interval_timer #(
    .WIDTH(32)
  ) u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(idle_load),
    .stop(state != ST_IDLE),
    .value(idle_len),
    .expired(idle_expired)
  );

  ////////////////////////////////////////////////////////////////////////
  // decode of settings and strap
  // an illegal strap code falls back to the line variant, the safe one
  assign line_variant = (variant_sel != VAR_EARLY_SUPPLY) && (variant_sel != VAR_SUPPLY);
  assign edrx_variant = (variant_sel != VAR_EARLY_SUPPLY);
  assign lp_en = ctrl[CTRL_LP_EN];
  assign pos_busy = ctrl[CTRL_POS_EN] && net.positioning_busy;
  assign psm_ok = lp_en && ctrl[CTRL_PSM_EN] && net.psm_allowed && !pos_busy;
  assign edrx_ok = lp_en && ctrl[CTRL_EDRX_EN] && edrx_variant
                   && (edrx_cycle >= EDRX_DS_MIN_MS) && !net.ptw_active && !pos_busy;
  assign seq_done = (seq_cnt == 16'(SWITCH_CYC - 1));
  assign dwell_done = (seq_cnt >= 16'(DWELL_CYC - 1));
  assign cmd_ok = cmd_mode(state);

  // idle length: profile scales the base, edrx stretches, positioning halves
  always_comb
  begin
    idle_len = idle_base;
    unique case (ctrl[CTRL_LPM_LSB +: 2])
      2'b01: idle_len = {idle_base[30:0], 1'b0};
      2'b10: idle_len = {idle_base[29:0], 2'b00};
      default: idle_len = idle_base;
    endcase
    if (ctrl[CTRL_EDRX_EN] && (edrx_cycle != 32'h0000_0000))
      idle_len = {idle_len[30:0], 1'b0};
    if (pos_busy)
      idle_len = {1'b0, idle_len[31:1]};
  end

  ////////////////////////////////////////////////////////////////////////
  // mode state machine, next mode
  always_comb
  begin
    next_state = state;
    idle_load = 1'b0;
    if (!supply_valid)
      next_state = ST_NOT_POWERED;
    else
    begin
      unique case (state)
        ST_NOT_POWERED:
          next_state = line_variant ? ST_POWER_OFF : ST_SWITCH_ON;
        ST_POWER_OFF:
          if (pwr_pulse)
            next_state = ST_SWITCH_ON;
        ST_SWITCH_ON:
          if (seq_done)
            next_state = ST_ACTIVE;
        ST_ACTIVE:
          if (poweroff_pend)
            next_state = ST_SWITCH_OFF;
          else if (net.radio_active)
            next_state = ST_CONNECTED;
          else if (dwell_done && psm_ok)
            next_state = ST_DEEP_SLEEP;
          else if (dwell_done && edrx_ok)
            next_state = ST_DEEP_SLEEP;
          else if (dwell_done && lp_en)
          begin
            next_state = ST_IDLE;
            idle_load = 1'b1;
          end
        ST_CONNECTED:
          if (poweroff_pend)
            next_state = ST_SWITCH_OFF;
          else if (!net.radio_active)
            next_state = ST_ACTIVE;
        ST_IDLE:
          // any reason to work returns to active; low power off also ends idle
          if (idle_expired || net.radio_active || pwr_pulse || poweroff_pend || !lp_en)
            next_state = ST_ACTIVE;
          else if (psm_ok || edrx_ok)
            next_state = ST_DEEP_SLEEP;
        ST_DEEP_SLEEP:
          // the wake-up routine reuses the switch-on sequence
          if (pwr_pulse || (!deep_edrx && net.psm_timer_expiry)
              || (deep_edrx && net.ptw_start))
            next_state = ST_SWITCH_ON;
        ST_SWITCH_OFF:
          if (seq_done)
            next_state = ST_POWER_OFF;
      endcase
    end
  end

  // mode register; status output is the register itself
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state <= ST_NOT_POWERED;
    else
      state <= next_state;
  end

  // psm is preferred when both sleeps are possible
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      deep_edrx <= 1'b0;
    else if ((next_state == ST_DEEP_SLEEP) && (state != ST_DEEP_SLEEP))
      deep_edrx <= !psm_ok;
  end

  // routine and dwell counter, restarts on every mode change
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      seq_cnt <= 16'h0000;
    else if (next_state != state)
      seq_cnt <= 16'h0000;
    else if (seq_cnt != 16'hffff)
      seq_cnt <= seq_cnt + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////
  // domain controls, registered from the next mode so they move with it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rtc_run <= 1'b0;
      core_run <= 1'b0;
      core_clk_fast <= 1'b0;
      if_ready <= 1'b0;
      radio_path_en <= 1'b0;
      vint_on <= 1'b0;
    end
    else
    begin
      rtc_run <= (next_state != ST_NOT_POWERED) && (next_state != ST_POWER_OFF);
      core_run <= vint_mode(next_state);
      core_clk_fast <= vint_mode(next_state) && (next_state != ST_IDLE);
      if_ready <= (next_state == ST_ACTIVE) || (next_state == ST_CONNECTED);
      radio_path_en <= (next_state == ST_CONNECTED);
      vint_on <= vint_mode(next_state);
    end
  end

  assign mode_status = state;

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ok = hsel && htrans[1] && hready;
  assign wr_fire = wr_pend;

  // capture write address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      wr_pend <= addr_ok && hwrite && (hsize == 3'b010);
      wr_addr <= haddr[7:0];
    end
  end

  // read data sampled at the address phase; unmapped reads give zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (addr_ok && !hwrite)
    begin
      unique case (haddr[7:0])
        OFS_CTRL: hrdata <= {26'h0, ctrl};
        OFS_IDLE_BASE: hrdata <= idle_base;
        OFS_EDRX_CYCLE: hrdata <= edrx_cycle;
        OFS_STATUS: hrdata <= {24'h0, poweroff_pend, deep_edrx, variant_sel, 1'b0, state};
        OFS_IRQ_STATUS: hrdata <= {28'h0, irq_status};
        OFS_IRQ_ENABLE: hrdata <= {28'h0, irq_enable};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // configuration, taken only in idle, active and connected modes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl <= CTRL_RST;
      idle_base <= IDLE_BASE_RST;
      edrx_cycle <= EDRX_CYCLE_RST;
    end
    else if (wr_fire && cmd_ok)
    begin
      if (wr_addr == OFS_CTRL)
        ctrl <= hwdata[5:0];
      if (wr_addr == OFS_IDLE_BASE)
        idle_base <= hwdata;
      if (wr_addr == OFS_EDRX_CYCLE)
        edrx_cycle <= hwdata;
    end
  end

  // pending graceful switch-off; dropped once it is under way or power goes
  assign poweroff_set = wr_fire && cmd_ok && (wr_addr == OFS_CMD) && hwdata[CMD_POWEROFF];
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      poweroff_pend <= 1'b0;
    else if (poweroff_set)
      poweroff_pend <= 1'b1;
    else if ((state == ST_SWITCH_OFF) || !vint_mode(state))
      poweroff_pend <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupts
  assign irq_event[IRQ_MODE] = (next_state != state);
  assign irq_event[IRQ_WAKE] = ((state == ST_DEEP_SLEEP) || (state == ST_IDLE))
                               && (next_state == ST_SWITCH_ON || next_state == ST_ACTIVE);
  assign irq_event[IRQ_OFF] = (state == ST_SWITCH_OFF) && (next_state == ST_POWER_OFF);
  assign irq_event[IRQ_SUPPLY] = (state != ST_NOT_POWERED) && !supply_valid;
  assign irq_clear = (wr_fire && (wr_addr == OFS_IRQ_CLEAR)) ? hwdata[3:0] : 4'h0;

  // mask register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_enable <= IRQ_RST;
    else if (wr_fire && (wr_addr == OFS_IRQ_ENABLE))
      irq_enable <= hwdata[3:0];
  end

  // sticky status: a new event beats a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_status <= IRQ_RST;
    else
      irq_status <= (irq_status & ~irq_clear) | irq_event;
  end

  assign irq = |(irq_status & irq_enable);

endmodule : oms_sequencer

// file: test/oms_sequencer_assertions.sv
/*
  checker of the sequencer's ports, bound to its top module.
  assumes one clock domain, reset released on an hclk edge.
*/
`timescale 1ns/1ps
module oms_chk
  import oms_pkg::*;
(
  input logic hclk,
  input logic hresetn,
  input logic supply_valid,
  input logic [1:0] variant_sel,
  input oms_net_s net,
  input oms_state_e mode_status,
  input logic rtc_run,
  input logic core_run,
  input logic core_clk_fast,
  input logic if_ready,
  input logic radio_path_en,
  input logic vint_on
);
  // all on hclk, quiet in reset
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////
  property p_no_supply;
    !supply_valid |=> mode_status == ST_NOT_POWERED;
  endproperty
  a_no_supply: assert property (p_no_supply) else $error("supply loss kept mode");
  // strap bit 1 picks the line trigger; the mode moves on the next edge and holds
  property p_power_up;
    mode_status == ST_NOT_POWERED && supply_valid ##1 supply_valid
      |=> mode_status == (variant_sel[1] ? ST_POWER_OFF : ST_SWITCH_ON);
  endproperty
  a_power_up: assert property (p_power_up) else $error("wrong mode after supply");
  property p_vint;
    vint_on == !(mode_status inside {ST_NOT_POWERED, ST_POWER_OFF, ST_DEEP_SLEEP});
  endproperty
  a_vint: assert property (p_vint) else $error("supply monitor level wrong");
  property p_deep;
    mode_status == ST_DEEP_SLEEP |-> rtc_run && !core_run && !if_ready;
  endproperty
  a_deep: assert property (p_deep) else $error("deep sleep domains wrong");
  property p_idle;
    mode_status == ST_IDLE |-> core_run && !core_clk_fast && !radio_path_en;
  endproperty
  a_idle: assert property (p_idle) else $error("idle clocking wrong");
  property p_active;
    mode_status inside {ST_ACTIVE, ST_CONNECTED}
      |-> core_clk_fast && if_ready && (radio_path_en == (mode_status == ST_CONNECTED));
  endproperty
  a_active: assert property (p_active) else $error("active controls wrong");
  property p_radio;
    mode_status == ST_ACTIVE && net.radio_active && supply_valid
      |=> mode_status inside {ST_CONNECTED, ST_SWITCH_OFF};
  endproperty
  a_radio: assert property (p_radio) else $error("radio did not connect");
  property p_idle_entry;
    $rose(mode_status == ST_IDLE) |-> $past(mode_status) == ST_ACTIVE;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle entered off active");
  // 200-cycle routines plus ten of margin
  property p_routine;
    $rose(mode_status inside {ST_SWITCH_ON, ST_SWITCH_OFF})
      |-> ##[1:210] mode_status inside {ST_ACTIVE, ST_POWER_OFF, ST_NOT_POWERED};
  endproperty
  a_routine: assert property (p_routine) else $error("routine overran");
  property p_ds_exit;
    mode_status == ST_DEEP_SLEEP
      |=> mode_status inside {ST_DEEP_SLEEP, ST_SWITCH_ON, ST_NOT_POWERED};
  endproperty
  a_ds_exit: assert property (p_ds_exit) else $error("deep sleep left wrongly");
endmodule : oms_chk

bind oms_sequencer oms_chk oms_chk_i (
  .hclk(hclk), .hresetn(hresetn), .supply_valid(supply_valid),
  .variant_sel(variant_sel), .net(net), .mode_status(mode_status),
  .rtc_run(rtc_run), .core_run(core_run), .core_clk_fast(core_clk_fast),
  .if_ready(if_ready), .radio_path_en(radio_path_en), .vint_on(vint_on)
);

// file: test/oms_host_model.sv
/*
  host side of the power-on line: holds it low for a set count.
  assumes a pull-up on the line whenever it is let go.
*/
`timescale 1ns/1ps
module oms_host_model
(
  input wire logic hclk,
  input wire logic press,
  input wire logic [15:0] hold_cyc,
  output logic power_on_request_n,
  output logic busy
);
  logic [15:0] left = 16'h0; // low cycles still to hold
  initial busy = 1'h0;
  // a press is taken only while idle; short counts model a bad host
  always @(posedge hclk)
  begin
    if (press && !busy)
    begin
      left <= hold_cyc;
      busy <= 1'h1;
    end
    else if (busy && left <= 16'h1)
      busy <= 1'h0;
    else if (busy)
      left <= left - 16'h1;
  end
  // released line rests at the pull-up level
  assign power_on_request_n = !busy;
endmodule : oms_host_model

// file: test/test_oms_sequencer.sv
/*
  self-checking bench of the mode sequencer.
  assumes the checker binds itself and the host model sits beside.
*/
`timescale 1ns/1ps
module test_oms_sequencer
  import oms_pkg::*;
;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2; // whole words only
  logic [31:0] hwdata = 32'h0;
  logic hready; // the single slave's ready
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic supply_valid = 1'h0;
  logic [1:0] variant_sel = 2'h1;
  oms_net_s net = '0;
  oms_state_e mode_status;
  logic rtc_run, core_run, core_clk_fast, if_ready, radio_path_en, vint_on, irq;
  logic power_on_request_n;
  logic press = 1'h0;
  logic [15:0] hold_cyc = 16'h0;
  logic [31:0] rdv; // last word read
  int errors = 0;
  int num_checks = 0;
  assign hready = hreadyout;
  oms_sequencer oms_sequencer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .supply_valid(supply_valid), .variant_sel(variant_sel),
    .power_on_request_n(power_on_request_n), .net(net), .mode_status(mode_status),
    .rtc_run(rtc_run), .core_run(core_run), .core_clk_fast(core_clk_fast),
    .if_ready(if_ready), .radio_path_en(radio_path_en), .vint_on(vint_on), .irq(irq));
  oms_host_model oms_host_model_i (.hclk(hclk), .press(press), .hold_cyc(hold_cyc),
    .power_on_request_n(power_on_request_n), .busy());
  initial forever #50 hclk = ~hclk;
  ////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t %s got %h", $time, what, got);
    end
  endtask : chk
  // bounded wait for ready; a stuck bus ends the run
  task automatic rdy_wait;
    int n = 0;
    @(posedge hclk);
    while (hready !== 1'h1 && n < 16)
    begin
      @(posedge hclk);
      n++;
    end
    chk({hready, hresp}, 32'h2, "bus ready okay");
    if (hready !== 1'h1)
      test_done();
  endtask : rdy_wait
  task automatic bus(input logic wr, input logic [31:0] a, d = 32'h0);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    rdy_wait();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy_wait();
    rdv = hrdata;
  endtask : bus
  task automatic wait_mode(input oms_state_e m, input int lim);
    int n = 0;
    while (mode_status !== m && n < lim)
    begin
      @(negedge hclk);
      n++;
    end
    chk(mode_status, m, "mode wait");
    if (mode_status !== m)
      test_done();
  endtask : wait_mode
  task automatic do_reset(input logic [1:0] v);
    @(posedge hclk);
    hresetn <= 1'h0;
    variant_sel <= v;
    supply_valid <= 1'h1;
    net <= '0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
  endtask : do_reset
  task automatic press_line(input logic [15:0] n);
    @(posedge hclk);
    hold_cyc <= n;
    press <= 1'h1;
    @(posedge hclk);
    press <= 1'h0;
  endtask : press_line
  ////////////////////////////////////////////////////////////////////////
  task automatic t_start;
    do_reset(2'h1);
    wait_mode(ST_ACTIVE, 260);
    chk({if_ready, core_clk_fast, vint_on, radio_path_en}, 32'he, "active");
    bus(1'h0, OFS_IDLE_BASE);
    chk(rdv, IDLE_BASE_RST, "idle rst");
    bus(1'h1, 32'h40, 32'hffff_ffff);
    bus(1'h0, 32'h40);
    chk(rdv, 32'h0, "unmapped");
    bus(1'h0, OFS_STATUS);
    chk(rdv, 32'h14, "status");
    @(posedge hclk);
    net.radio_active <= 1'h1;
    wait_mode(ST_CONNECTED, 4);
    @(posedge hclk);
    net.radio_active <= 1'h0;
    wait_mode(ST_ACTIVE, 4);
    $display("test start done");
  endtask : t_start
  // idle length, profile and wake irq
  task automatic t_idle;
    bus(1'h1, OFS_IRQ_ENABLE, 32'h2);
    bus(1'h1, OFS_IDLE_BASE, 32'h10);
    bus(1'h1, OFS_CTRL, 32'h1);
    wait_mode(ST_IDLE, 520);
    wait_mode(ST_ACTIVE, 30);
    @(negedge hclk);
    chk(irq, 1'h1, "wake irq");
    bus(1'h0, OFS_IRQ_STATUS);
    chk(rdv, 32'h3, "irq status");
    bus(1'h1, OFS_IRQ_ENABLE, 32'h0);
    @(negedge hclk);
    chk(irq, 1'h0, "irq masked");
    bus(1'h1, OFS_IRQ_ENABLE, 32'h2);
    bus(1'h1, OFS_IRQ_CLEAR, 32'hf);
    @(negedge hclk);
    chk(irq, 1'h0, "irq cleared");
    bus(1'h1, OFS_CTRL, 32'h21);
    wait_mode(ST_IDLE, 520);
    repeat (50) @(negedge hclk);
    chk(mode_status, ST_IDLE, "profile idle");
    wait_mode(ST_ACTIVE, 30);
    $display("test idle done");
  endtask : t_idle
  task automatic t_psm;
    @(posedge hclk);
    net.psm_allowed <= 1'h1;
    bus(1'h1, OFS_CTRL, 32'h3);
    wait_mode(ST_DEEP_SLEEP, 520);
    chk({rtc_run, core_run, vint_on, if_ready}, 32'h8, "deep sleep");
    bus(1'h1, OFS_CTRL, 32'h0);
    @(posedge hclk);
    net.psm_timer_expiry <= 1'h1;
    net.psm_allowed <= 1'h0;
    @(posedge hclk);
    net.psm_timer_expiry <= 1'h0;
    wait_mode(ST_SWITCH_ON, 3);
    wait_mode(ST_ACTIVE, 210);
    bus(1'h0, OFS_CTRL);
    chk(rdv, 32'h3, "sleep wr");
    bus(1'h1, OFS_CMD, 32'h1);
    wait_mode(ST_SWITCH_OFF, 4);
    wait_mode(ST_POWER_OFF, 210);
    bus(1'h0, OFS_IRQ_STATUS);
    chk(rdv & 32'h4, 32'h4, "off done");
    @(posedge hclk);
    supply_valid <= 1'h0;
    wait_mode(ST_NOT_POWERED, 2);
    @(posedge hclk);
    supply_valid <= 1'h1;
    $display("test psm done");
  endtask : t_psm
  task automatic t_edrx;
    wait_mode(ST_ACTIVE, 260);
    bus(1'h1, OFS_EDRX_CYCLE, EDRX_DS_MIN_MS);
    bus(1'h1, OFS_CTRL, 32'h5);
    wait_mode(ST_DEEP_SLEEP, 520);
    bus(1'h0, OFS_STATUS);
    chk(rdv, 32'h52, "edrx status");
    @(posedge hclk);
    net.ptw_start <= 1'h1;
    net.ptw_active <= 1'h1;
    @(posedge hclk);
    net.ptw_start <= 1'h0;
    wait_mode(ST_SWITCH_ON, 3);
    wait_mode(ST_IDLE, 800);
    do_reset(2'h0);
    wait_mode(ST_ACTIVE, 260);
    bus(1'h1, OFS_EDRX_CYCLE, EDRX_DS_MIN_MS);
    bus(1'h1, OFS_CTRL, 32'h5);
    wait_mode(ST_IDLE, 520);
    repeat (100) @(negedge hclk);
    chk(mode_status, ST_IDLE, "early no edrx");
    $display("test edrx done");
  endtask : t_edrx
  task automatic t_line;
    do_reset(2'h2);
    repeat (3) @(negedge hclk);
    chk({mode_status, vint_on}, {ST_POWER_OFF, 1'h0}, "line waits");
    bus(1'h1, OFS_CTRL, 32'h3);
    press_line(16'h14);
    repeat (1100) @(negedge hclk);
    chk(mode_status, ST_POWER_OFF, "short press");
    press_line(16'h44c);
    wait_mode(ST_SWITCH_ON, 1200);
    wait_mode(ST_ACTIVE, 210);
    bus(1'h0, OFS_CTRL);
    chk(rdv, 32'h0, "off wr");
    @(posedge hclk);
    net.psm_allowed <= 1'h1;
    bus(1'h1, OFS_CTRL, 32'h3);
    wait_mode(ST_DEEP_SLEEP, 520);
    press_line(16'h44c);
    wait_mode(ST_SWITCH_ON, 1200);
    $display("test line done");
  endtask : t_line
  initial
  begin
    t_start();
    t_idle();
    t_psm();
    t_edrx();
    t_line();
    test_done();
  end
endmodule : test_oms_sequencer
